// file: core/pulse_counter_map.svh
// register map and constants of the fast pulse counter
`ifndef PULSE_COUNTER_MAP_SVH
`define PULSE_COUNTER_MAP_SVH

`define ADDR_CTRL 4'h0
`define ADDR_START 4'h1
`define ADDR_COUNT 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_CLEAR 4'h4
`define ADDR_IRQ_EN 4'h5

`define CTRL_EN_BIT 0
`define CTRL_EXT_BIT 1
`define CTRL_LOAD_BIT 2

`define ST_ZERO_BIT 0
`define ST_WRAP_BIT 1

`define CTRL_RESET 3'h0
`define START_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define COUNT_MINUS_ONE 16'hFFFF
`define COUNT_MAX_POS 16'h7FFF
`define IRQ_RESET 2'h0

`define MAX_PULSE_HZ 50000
`define CLOCK_HZ 25000000

`endif

// file: core/pulse_counter_pkg.sv
// types shared by the fast pulse counter modules
package pulse_counter_pkg;
   typedef logic [15:0] count_t;
   typedef enum logic [1:0] {
      LOAD_IDLE = 2'h0,
      LOAD_HOLD = 2'h1
   } load_state_e;
endpackage

// file: core/input_sync.sv
// two-flop synchroniser with rising-edge detect on the second stage
`timescale 1ns/1ps
module input_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   // edge seen only after the second stage
   assign rise_o = sync_q & ~prev_q;
endmodule // input_sync

// file: core/event_flags.sv
// sticky event flags with write-one-to-clear and enable mask
`timescale 1ns/1ps
module event_flags #(
   parameter int WIDTH = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clear_i,
   input wire logic [WIDTH-1:0] enable_i,
   output logic [WIDTH-1:0] flags_o,
   output logic irq_o
);
   logic [WIDTH-1:0] flags_q;
   logic irq_q;

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_flag
         // a set in the clearing cycle wins, so no event is lost
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               flags_q[g] <= 1'b0;
            end else if (set_i[g]) begin
               flags_q[g] <= 1'b1;
            end else if (clear_i[g]) begin
               flags_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |((flags_q | set_i) & ~(clear_i & ~set_i) & enable_i);
      end
   end

   assign flags_o = flags_q;
   assign irq_o = irq_q;
endmodule // event_flags

// file: core/fast_pulse_counter.sv
// fast pulse counter: 16-bit up-counter with start value load and zero-crossing flag
// How it works
// RULE1: after a load the count starts at the start value and steps up by one per counted pulse, upward only.
// RULE2: a pulse at 7FFF wraps the count to 8000 and counting carries on upward.
// RULE3: the zero-crossing flag rises when the count steps from FFFF to 0000, also after a wrap.
// RULE4: counting goes on through wraps until the enable drops or a new start value is loaded.
// RULE5: a start value of 8000 is accepted and gives a zero crossing after 32768 pulses.
// RULE6: a start value of one gives a zero crossing after 65535 pulses through the wrap.
// RULE7: with the external select set the external enable gates counting and the flag drives the output pin.
// RULE8: while the load bit is set the start value is copied into the counter; software may drive it from the flag.
// RULE9: the counter is 16 bits and keeps up with pulse rates to 50 kHz.
// RULE10: only rising edges of the pulse input are counted.
// RULE11: with the external select clear the internal enable bit gates counting.
// RULE12: loading a start value clears the zero-crossing flag.
// RULE13: pulse and enable inputs are synchronised before use; only the pulse is edge-detected, the enable gates as a level.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module fast_pulse_counter
   import pulse_counter_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic PULSE_I,
   input wire logic EXT_ENABLE_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [15:0] RDATA_O,
   output logic ZERO_CROSS_O,
   output logic IRQ_O
);
   // a 50 kHz pulse gives this many clocks per period; the sync path needs three
   localparam int CYCLES_PER_PULSE = `CLOCK_HZ / `MAX_PULSE_HZ; // RULE9

   logic [2:0] ctrl_q;
   count_t start_q;
   count_t count_q;
   count_t count_d;
   logic zero_q;
   logic [15:0] rdata_q;
   logic zero_pin_q;
   logic [1:0] irq_en_q;
   load_state_e load_q;
   load_state_e load_d;

   logic pulse_rise;
   logic ext_level;
   logic [1:0] flags;
   logic irq;

   input_sync u_pulse_sync (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .async_i(PULSE_I),
      .level_o(),
      .rise_o(pulse_rise)
   ); // RULE13

   input_sync u_enable_sync (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .async_i(EXT_ENABLE_I),
      .level_o(ext_level),
      .rise_o()
   ); // RULE13

   // decode
   wire wr_ctrl = WR_I && (ADDR_I == `ADDR_CTRL);
   wire wr_start = WR_I && (ADDR_I == `ADDR_START);
   wire wr_clear = WR_I && (ADDR_I == `ADDR_CLEAR);
   wire wr_irq_en = WR_I && (ADDR_I == `ADDR_IRQ_EN);

   wire ext_sel = ctrl_q[`CTRL_EXT_BIT];
   wire load_req = ctrl_q[`CTRL_LOAD_BIT]; // RULE8
   // counting gate: external pin or internal bit
   wire count_en = ext_sel ? ext_level : ctrl_q[`CTRL_EN_BIT]; // RULE7 RULE11
   wire step = count_en && pulse_rise && !load_req; // RULE10 RULE4
   // plain 16-bit increment: 7FFF+1 = 8000 and FFFF+1 = 0000 come for free
   wire [15:0] count_inc = count_q + 16'h0001; // RULE1 RULE2 RULE5 RULE6
   wire zero_event = step && (count_q == `COUNT_MINUS_ONE); // RULE3
   wire wrap_event = step && (count_q == `COUNT_MAX_POS); // RULE2

   always_comb begin
      count_d = count_q;
      if (load_req) begin
         count_d = start_q; // RULE8
      end else if (step) begin
         count_d = count_inc; // RULE1
      end
   end

   // load tracker follows the load request one cycle late, in LOAD_HOLD for as long as it is held
   always_comb begin
      case (load_q)
         LOAD_IDLE: load_d = load_req ? LOAD_HOLD : LOAD_IDLE;
         LOAD_HOLD: load_d = load_req ? LOAD_HOLD : LOAD_IDLE;
         default: load_d = LOAD_IDLE;
      endcase
   end

   wire [15:0] rd_mux =
      (ADDR_I == `ADDR_CTRL) ? {13'h0000, ctrl_q} :
      (ADDR_I == `ADDR_START) ? start_q :
      (ADDR_I == `ADDR_COUNT) ? count_q :
      (ADDR_I == `ADDR_STATUS) ? {13'h0000, zero_q, flags} :
      (ADDR_I == `ADDR_IRQ_EN) ? {14'h0000, irq_en_q} :
      16'h0000;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_q <= `CTRL_RESET;
         start_q <= `START_RESET;
         irq_en_q <= `IRQ_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= WDATA_I[2:0];
         end
         if (wr_start) begin
            start_q <= WDATA_I;
         end
         if (wr_irq_en) begin
            irq_en_q <= WDATA_I[1:0];
         end
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         count_q <= `COUNT_RESET;
         load_q <= LOAD_IDLE;
      end else begin
         count_q <= count_d;
         load_q <= load_d;
      end
   end

   // zero-crossing level flag; a load cancels it
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         zero_q <= 1'b0;
      end else if (load_req) begin
         zero_q <= 1'b0; // RULE12
      end else if (zero_event) begin
         zero_q <= 1'b1; // RULE3
      end
   end

   // pin shows the flag only in external mode; registered for a clean output
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         zero_pin_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         zero_pin_q <= ext_sel && zero_q; // RULE7
         rdata_q <= RD_I ? rd_mux : 16'h0000;
      end
   end

   event_flags #(
      .WIDTH(2)
   ) u_flags (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .set_i({wrap_event, zero_event}),
      .clear_i(wr_clear ? WDATA_I[1:0] : 2'h0),
      .enable_i(irq_en_q),
      .flags_o(flags),
      .irq_o(irq)
   );

   assign RDATA_O = rdata_q;
   assign ZERO_CROSS_O = zero_pin_q;
   assign IRQ_O = irq;
endmodule // fast_pulse_counter

// file: testbench/fast_pulse_counter_sva.sv
// port-level assertions for the fast pulse counter
`timescale 1ns/1ps
module fast_pulse_counter_sva (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic PULSE_I,
   input wire logic EXT_ENABLE_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [15:0] RDATA_O,
   input wire logic ZERO_CROSS_O,
   input wire logic IRQ_O
);
   // shadows of the writable registers, rebuilt from bus writes
   logic [2:0] ctrl_q;
   logic [15:0] start_q;
   logic [1:0] irq_en_q;
   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_q <= 3'h0;
         start_q <= 16'h0000;
         irq_en_q <= 2'h0;
      end else if (WR_I) begin
         if (ADDR_I == 4'h0) ctrl_q <= WDATA_I[2:0];
         if (ADDR_I == 4'h1) start_q <= WDATA_I;
         if (ADDR_I == 4'h5) irq_en_q <= WDATA_I[1:0];
      end
   end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
      else $error("read data not zero outside a read");
   a_rdata_unmapped: assert property ($past(RD_I) && $past(ADDR_I) > 4'h5 |-> RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   a_ctrl_readback: assert property ($past(RD_I) && $past(ADDR_I) == 4'h0 |-> RDATA_O == {13'h0, $past(ctrl_q)})
      else $error("control readback wrong");
   a_start_readback: assert property ($past(RD_I) && $past(ADDR_I) == 4'h1 |-> RDATA_O == $past(start_q))
      else $error("start value readback wrong");
   a_zc_pin_gate: assert property (ZERO_CROSS_O |-> ctrl_q[1] || $past(ctrl_q[1]))
      else $error("zero pin high without external select");
   a_irq_masked: assert property (IRQ_O |-> irq_en_q != 2'h0 || $past(irq_en_q) != 2'h0)
      else $error("interrupt high while masked");
   a_load_clears_zc: assert property (WR_I && ADDR_I == 4'h0 && WDATA_I[2] |-> ##3 !ZERO_CROSS_O)
      else $error("load left zero pin set");
   a_load_copies: assert property ($past(RD_I) && $past(ADDR_I) == 4'h2 && $past(ctrl_q[2], 2)
      && $past(start_q, 2) == $past(start_q) |-> RDATA_O == $past(start_q))
      else $error("held load did not copy start value");
   cover property ($rose(ZERO_CROSS_O));
   cover property ($rose(IRQ_O));
   cover property ($past(RD_I) && $past(ADDR_I) == 4'h2);
endmodule // fast_pulse_counter_sva

bind fast_pulse_counter fast_pulse_counter_sva i_sva (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .PULSE_I(PULSE_I),
   .EXT_ENABLE_I(EXT_ENABLE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .ZERO_CROSS_O(ZERO_CROSS_O), .IRQ_O(IRQ_O));

// file: testbench/pulse_source.sv
// model of the machine's count pulse line
`timescale 1ns/1ps
module pulse_source (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic [7:0] count_i,
   output logic pulse_o,
   output logic busy_o
);
   initial begin
      pulse_o = 1'b0;
      busy_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (start_i) begin
            busy_o <= 1'b1;
            // two cycles per level is the fastest the synchroniser can follow
            repeat (count_i) begin
               repeat (2) @(posedge clk_i);
               pulse_o <= 1'b1;
               repeat (2) @(posedge clk_i);
               pulse_o <= 1'b0;
            end
            busy_o <= 1'b0;
         end
      end
   end
endmodule // pulse_source

// file: testbench/fast_pulse_counter_tb_top.sv
// self-checking bench for the fast pulse counter
`timescale 1ns/1ps
`include "pulse_counter_map.svh"
module fast_pulse_counter_tb_top import pulse_counter_pkg::*; ;
   logic clk, rst, ext_en, wr, rd, go;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic [7:0] npulse;
   wire logic [15:0] rdata;
   wire logic pulse, zc, irq, busy;
   int miscompares = 0;
   int checked = 0;
   count_t start;
   int n;
   always #20 clk = ~clk;
   fast_pulse_counter i_dut (.CLOCK_I(clk), .RST_I(rst), .PULSE_I(pulse), .EXT_ENABLE_I(ext_en), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ZERO_CROSS_O(zc), .IRQ_O(irq));
   pulse_source i_src (.clk_i(clk), .start_i(go), .count_i(npulse), .pulse_o(pulse), .busy_o(busy));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdr(input logic [3:0] a, input logic [15:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk($sformatf("reg %0h", a), exp, rdata);
      @(posedge clk);
   endtask
   task automatic ld(input logic [15:0] s, input logic [15:0] c);
      wrr(`ADDR_START, s);
      wrr(`ADDR_CTRL, c | 16'h0004);
      wrr(`ADDR_CTRL, c);
   endtask
   task automatic run(input logic [7:0] k);
      npulse <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end
   initial begin
      {clk, ext_en, wr, rd, go, addr, wdata, npulse} = '0;
      rst = 1'b1;
      void'($urandom(65504));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 8; a++) if (a != 4) rdr(4'(a), 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         start = 16'h0100 + 16'($urandom % 24576);
         n = 1 + $urandom % 9;
         ld(start, 16'h0001);
         run(8'(n));
         rdr(`ADDR_COUNT, start + 16'(n));
         wrr(`ADDR_CTRL, 16'h0000);
         run(8'h3);
         rdr(`ADDR_COUNT, start + 16'(n));
      end
      $display("test random count done");
      wrr(`ADDR_START, `COUNT_MAX_POS - 16'h0001);
      wrr(`ADDR_CTRL, 16'h0004);
      rdr(`ADDR_COUNT, 16'h7FFE);
      wrr(`ADDR_CTRL, 16'h0001);
      run(8'h3);
      rdr(`ADDR_COUNT, 16'h8001);
      rdr(`ADDR_STATUS, 16'h0002);
      wrr(`ADDR_CLEAR, 16'h0003);
      $display("test wrap done");
      wrr(`ADDR_IRQ_EN, 16'h0001);
      ld(16'hFFFD, 16'h0002);
      run(8'h2);
      rdr(`ADDR_COUNT, 16'hFFFD);
      ext_en <= 1'b1;
      run(8'h3);
      chk("zero pin", 16'h0001, {15'h0, zc});
      chk("irq", 16'h0001, {15'h0, irq});
      rdr(`ADDR_STATUS, 16'h0005);
      wrr(`ADDR_CLEAR, 16'h0001);
      rdr(`ADDR_STATUS, 16'h0004);
      chk("irq cleared", 16'h0000, {15'h0, irq});
      ld(16'h8000, 16'h0002);
      chk("zero pin load", 16'h0000, {15'h0, zc});
      rdr(`ADDR_COUNT, 16'h8000);
      rdr(`ADDR_STATUS, 16'h0000);
      $display("test zero crossing done");
      end_sim();
   end
endmodule // fast_pulse_counter_tb_top
